/* logic/vsc_arbiter_map.vh */
// Purpose: constants for the backplane system controller arbiter
// Assumes: 25 MHz core clock (40 ns)
// Notes: offsets index 32-bit registers on the plain register port
`ifndef VSC_ARBITER_MAP_VH
`define VSC_ARBITER_MAP_VH

// ----------------------------------------
// timing
// ----------------------------------------
`define VSC_CLK_NS 40
`define VSC_TIMEOUT_US 48
`define VSC_TIMEOUT_CYC ((`VSC_TIMEOUT_US * 1000) / `VSC_CLK_NS)
`define VSC_SYSCLK_DIV 2
`define VSC_SYSRST_CYC 16

// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define VSC_OFS_CTRL 8'h00
`define VSC_OFS_STAT 8'h04
`define VSC_OFS_MASK 8'h08
`define VSC_OFS_STATE 8'h0c

// ----------------------------------------
// control fields
// ----------------------------------------
`define VSC_CTRL_LOCK 0
`define VSC_CTRL_RRCLR 1
`define VSC_CTRL_SYSRST 2
`define VSC_CTRL_RST 3'h0

// ----------------------------------------
// status bits (events)
// ----------------------------------------
`define VSC_EV_TIMEOUT 0
`define VSC_EV_GRANT 1
`define VSC_EV_CLEAR 2
`define VSC_EV_W 3

`endif

/* logic/vsc_arbiter.v */
// Purpose: system controller of a backplane adapter: arbiter, bus clear,
//          system clock and reset, bus timeout
// Assumes: straps static; backplane inputs synchronous, active high here
// Notes: own bus request is a plain input; grants go out one per level
//
// The implementer's own choices: the register offsets and the address-and-strobe port.
`include "vsc_arbiter_map.vh"

// Overview of operation
// - enabled controller arbitrates in one of three modes
// - own mastership releases on request unless locked or single level
// - single level: self first, grant level three only
// - priority: level three highest, zero lowest
// - priority: clear when pending outranks last grant
// - rotating: step levels after release until request
// - rotating: optional clear for other levels only
// - drive system clock and reset when controller
// - bus timeout at 48 us after cycle start
// - all requests on three: grants as single level, but self not first
// - all backplane outputs inactive unless strapped for slot one
// - mode from priority/rotating and multilevel straps
module vsc_arbiter #(
  parameter TIMEOUT_CYC = `VSC_TIMEOUT_CYC,
  parameter SYSRST_CYC = `VSC_SYSRST_CYC
) (
  input wire core_clk, // 25 MHz clock
  input wire rst, // async reset, active high
  input wire system_controller_enable_strap, // strapped for slot 1
  input wire multilevel_arbiter_select, // four-level arbiter on
  input wire rotating_arbitration, // 1 rotating, 0 fixed priority
  input wire [3:0] bus_request, // request levels 3..0
  input wire bus_busy_in, // bus busy seen on backplane
  input wire cycle_start, // address strobe asserted
  input wire cycle_ack, // slave acknowledge seen
  input wire own_request, // local side needs the bus
  input wire [7:0] reg_addr, // register address
  input wire [31:0] reg_wdata, // write data
  input wire reg_wr, // write strobe
  input wire reg_rd, // read strobe
  output reg [31:0] reg_rdata, // read data, cycle after strobe
  output reg [3:0] bus_grant, // grant out per level
  output reg bus_clear, // bus clear drive
  output reg own_grant, // local side owns the bus
  output reg bus_error, // bus error drive
  output reg sysclk, // backplane system clock
  output reg sysreset, // backplane system reset
  output reg irq // level interrupt
);

  localparam ST_IDLE = 3'b001;
  localparam ST_GRANT = 3'b010;
  localparam ST_BUSY = 3'b100;

  reg [2:0] state_reg;
  reg [1:0] last_lvl_reg;
  reg [1:0] rr_ptr_reg;
  reg [2:0] ctrl_reg;
  reg [`VSC_EV_W-1:0] stat_reg;
  reg [`VSC_EV_W-1:0] mask_reg;
  reg [15:0] tmo_cnt_reg;
  reg tmo_run_reg;
  reg cyc_prev_reg;
  reg [7:0] rst_cnt_reg;
  reg [3:0] div_reg;
  reg [1:0] pick_lvl;
  reg pick_ok;
  reg clear_next;
  reg [1:0] rr_idx;
  reg [1:0] cand;
  integer i;

  wire enabled = system_controller_enable_strap;
  wire locked = ctrl_reg[`VSC_CTRL_LOCK];
  // single level only when multilevel off; not set by the all-on-three case
  wire single_mode = !multilevel_arbiter_select;
  wire [3:0] req_eff = single_mode ? {bus_request[3], 3'h0} :
    bus_request;
  wire timeout_hit = tmo_run_reg &&
    (tmo_cnt_reg == TIMEOUT_CYC[15:0] - 16'h0001);
  wire [`VSC_EV_W-1:0] events;

  // ----------------------------------------
  // winner selection
  // ----------------------------------------
  // fixed priority takes highest level; rotating steps from last grant
  always @* begin
    pick_lvl = 2'h0;
    pick_ok = 1'b0;
    rr_idx = 2'h0;
    cand = 2'h0;
    if (rotating_arbitration && !single_mode) begin
      for (i = 1; i <= 4; i = i + 1) begin
        cand = rr_ptr_reg + i[1:0];
        if (!pick_ok && req_eff[cand]) begin
          pick_lvl = cand;
          pick_ok = 1'b1;
        end
      end
    end else begin
      for (i = 0; i < 4; i = i + 1) begin
        if (req_eff[i]) begin
          pick_lvl = i[1:0];
          pick_ok = 1'b1;
        end
      end
    end
    rr_idx = pick_lvl;
  end

  // ----------------------------------------
  // bus clear decision
  // ----------------------------------------
  always @* begin
    clear_next = 1'b0;
    if (enabled && !single_mode && state_reg == ST_BUSY) begin
      if (!rotating_arbitration) begin
        clear_next = bus_busy_in && pick_ok &&
          (pick_lvl > last_lvl_reg);
      end else if (ctrl_reg[`VSC_CTRL_RRCLR]) begin
        clear_next = |(bus_request &
          ~(4'h1 << last_lvl_reg));
      end
    end
  end

  assign events = {clear_next & ~bus_clear,
    state_reg == ST_GRANT, timeout_hit};

  // ----------------------------------------
  // arbitration state machine
  // ----------------------------------------
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_reg <= ST_IDLE;
      last_lvl_reg <= 2'h0;
      rr_ptr_reg <= 2'h3;
      bus_grant <= 4'h0;
      bus_clear <= 1'b0;
      own_grant <= 1'b0;
    end else if (!enabled) begin
      state_reg <= ST_IDLE;
      bus_grant <= 4'h0;
      bus_clear <= 1'b0;
      own_grant <= 1'b0;
    end else begin
      bus_clear <= clear_next & ~own_grant;
      case (state_reg)
        ST_IDLE: begin
          bus_grant <= 4'h0;
          if (own_grant) begin
            // keep bus while locked, or while own request holds in single level or while nobody else wants it
            if (!own_request && !locked) begin
              own_grant <= 1'b0;
            end else if (!locked && pick_ok && !single_mode) begin
              own_grant <= 1'b0;
            end
          end else if (own_request && (single_mode || !pick_ok)) begin
            own_grant <= 1'b1;
          end else if (!bus_busy_in && pick_ok && !own_request) begin
            bus_grant <= 4'h1 << pick_lvl;
            last_lvl_reg <= pick_lvl;
            rr_ptr_reg <= rr_idx;
            state_reg <= ST_GRANT;
          end else if (!bus_busy_in && pick_ok && !single_mode) begin
            bus_grant <= 4'h1 << pick_lvl;
            last_lvl_reg <= pick_lvl;
            rr_ptr_reg <= rr_idx;
            state_reg <= ST_GRANT;
          end
        end
        ST_GRANT: begin
          // hold grant until the winner takes busy or drops its request
          if (bus_busy_in) begin
            bus_grant <= 4'h0;
            state_reg <= ST_BUSY;
          end else if (!bus_request[last_lvl_reg]) begin
            bus_grant <= 4'h0;
            state_reg <= ST_IDLE;
          end
        end
        ST_BUSY: begin
          // owner releases in its own time after clear
          if (!bus_busy_in) begin
            state_reg <= ST_IDLE;
            bus_clear <= 1'b0;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // bus timeout timer
  // ----------------------------------------
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tmo_cnt_reg <= 16'h0000;
      tmo_run_reg <= 1'b0;
      bus_error <= 1'b0;
      cyc_prev_reg <= 1'b0;
    end else if (!enabled) begin
      tmo_cnt_reg <= 16'h0000;
      tmo_run_reg <= 1'b0;
      bus_error <= 1'b0;
      cyc_prev_reg <= cycle_start;
    end else begin
      // a cycle begins on the strobe's rising edge, not on its level
      cyc_prev_reg <= cycle_start;
      if (timeout_hit) begin
        bus_error <= 1'b1;
        tmo_run_reg <= 1'b0;
        tmo_cnt_reg <= 16'h0000;
      end else if (bus_error) begin
        bus_error <= cycle_start; // held until strobe drops
      end else if (cycle_ack) begin
        tmo_run_reg <= 1'b0;
        tmo_cnt_reg <= 16'h0000;
      end else if (cycle_start && !cyc_prev_reg && !tmo_run_reg) begin
        tmo_run_reg <= 1'b1;
        tmo_cnt_reg <= 16'h0000;
      end else if (tmo_run_reg) begin
        tmo_cnt_reg <= tmo_cnt_reg + 16'h0001;
      end
    end
  end

  // ----------------------------------------
  // system clock and reset
  // ----------------------------------------
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      div_reg <= 4'h0;
      sysclk <= 1'b0;
      rst_cnt_reg <= 8'h00;
      sysreset <= 1'b0;
    end else if (!enabled) begin
      div_reg <= 4'h0;
      sysclk <= 1'b0;
      rst_cnt_reg <= 8'h00;
      sysreset <= 1'b0;
    end else begin
      if (div_reg == `VSC_SYSCLK_DIV - 1) begin
        div_reg <= 4'h0;
        sysclk <= ~sysclk;
      end else begin
        div_reg <= div_reg + 4'h1;
      end
      // reset pulse after enable or on software request
      if (ctrl_reg[`VSC_CTRL_SYSRST]) begin
        rst_cnt_reg <= 8'h00;
        sysreset <= 1'b1;
      end else if (rst_cnt_reg != SYSRST_CYC[7:0]) begin
        rst_cnt_reg <= rst_cnt_reg + 8'h01;
        sysreset <= 1'b1;
      end else begin
        sysreset <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // register port and interrupt
  // ----------------------------------------
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ctrl_reg <= `VSC_CTRL_RST;
      stat_reg <= {`VSC_EV_W{1'b0}};
      mask_reg <= {`VSC_EV_W{1'b0}};
      reg_rdata <= 32'h00000000;
      irq <= 1'b0;
    end else begin
      reg_rdata <= 32'h00000000;
      if (reg_wr) begin
        if (reg_addr == `VSC_OFS_CTRL) begin
          ctrl_reg <= reg_wdata[2:0];
        end else if (reg_addr == `VSC_OFS_MASK) begin
          mask_reg <= reg_wdata[`VSC_EV_W-1:0];
        end
      end else begin
        ctrl_reg[`VSC_CTRL_SYSRST] <= 1'b0; // self-clearing
      end
      // read clears status; a same-cycle event still sets
      if (reg_rd && reg_addr == `VSC_OFS_STAT) begin
        stat_reg <= events;
      end else begin
        stat_reg <= stat_reg | events;
      end
      if (reg_rd) begin
        if (reg_addr == `VSC_OFS_CTRL) begin
          reg_rdata <= {29'h0, ctrl_reg};
        end else if (reg_addr == `VSC_OFS_STAT) begin
          reg_rdata <= {29'h0, stat_reg};
        end else if (reg_addr == `VSC_OFS_MASK) begin
          reg_rdata <= {29'h0, mask_reg};
        end else if (reg_addr == `VSC_OFS_STATE) begin
          reg_rdata <= {22'h0, own_grant, bus_clear, last_lvl_reg,
            rr_ptr_reg, state_reg, enabled};
        end
      end
      irq <= |(stat_reg & mask_reg);
    end
  end

endmodule // vsc_arbiter

/* testbench/vsc_arbiter_sva.sv */
// Purpose: port checks of the system controller arbiter
// Assumes: one clock domain, rst async active high
// Notes: bound to every arbiter instance
module vsc_arbiter_sva #(
  parameter TIMEOUT_CYC = 1200,
  parameter SYSRST_CYC = 16
) (
  input wire core_clk, // clock
  input wire rst, // reset
  input wire system_controller_enable_strap, // slot strap
  input wire multilevel_arbiter_select, // four levels
  input wire rotating_arbitration, // rotating
  input wire [3:0] bus_request, // requests
  input wire bus_busy_in, // busy
  input wire cycle_start, // strobe
  input wire cycle_ack, // acknowledge
  input wire reg_rd, // read strobe
  input wire [31:0] reg_rdata, // read data
  input wire [3:0] bus_grant, // grants
  input wire bus_clear, // clear
  input wire bus_error, // error
  input wire sysclk, // system clock
  input wire sysreset // system reset
);
  timeunit 1ns;
  timeprecision 1ns;
  wire en = system_controller_enable_strap;
  logic [7:0] rc;
  logic [15:0] tc;
  logic ak;
  logic [3:0] last;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // ------------------------------------
  // helper counters
  // ------------------------------------
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rc <= 8'h00;
      tc <= 16'h0000;
      ak <= 1'b0;
      last <= 4'h0;
    end else begin
      if (rc != 8'hff) rc <= rc + 8'h01;
      if (|bus_grant) last <= bus_grant;
      if (!cycle_start) begin
        tc <= 16'h0000;
        ak <= 1'b0;
      end else begin
        if (cycle_ack) ak <= 1'b1;
        if (tc != 16'hffff) tc <= tc + 16'h0001;
      end
    end
  end
  // ------------------------------------
  // assertions
  // ------------------------------------
  chk_grant_onehot: assert property ($onehot0(bus_grant))
    else $error("more than one grant");
  chk_single_three: assert property (en && !multilevel_arbiter_select
    |-> bus_grant[2:0] == 3'h0) else $error("single level grant");
  chk_slot_off: assert property (!en |-> bus_grant == 4'h0 && !bus_clear
    && !bus_error && !sysclk && !sysreset) else $error("slot off");
  chk_sysclk_rate: assert property (en && $changed(sysclk) |=>
    $stable(sysclk) ##1 $changed(sysclk)) else $error("sysclk rate");
  chk_sysreset_len: assert property (en && rc >= 2 && rc <= SYSRST_CYC - 2
    |-> sysreset) else $error("sysreset short");
  chk_timeout_early: assert property (tc > 0 && tc < TIMEOUT_CYC - 2
    |-> !bus_error) else $error("early bus error");
  chk_timeout_hit: assert property (en && !ak && tc == TIMEOUT_CYC + 2
    |-> bus_error) else $error("no bus error");
  chk_error_drop: assert property (!cycle_start [*3] |-> !bus_error)
    else $error("bus error stuck");
  chk_prio_clear: assert property (en && multilevel_arbiter_select
    && !rotating_arbitration && bus_busy_in && bus_request > last
    |-> ##[1:3] bus_clear) else $error("no bus clear");
  chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 0)
    else $error("read data outside slot");
endmodule // vsc_arbiter_sva

bind vsc_arbiter vsc_arbiter_sva #(.TIMEOUT_CYC(TIMEOUT_CYC),
  .SYSRST_CYC(SYSRST_CYC)) u_sva (.core_clk(core_clk), .rst(rst),
  .system_controller_enable_strap(system_controller_enable_strap),
  .multilevel_arbiter_select(multilevel_arbiter_select),
  .rotating_arbitration(rotating_arbitration),
  .bus_request(bus_request), .bus_busy_in(bus_busy_in),
  .cycle_start(cycle_start), .cycle_ack(cycle_ack), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .bus_grant(bus_grant), .bus_clear(bus_clear),
  .bus_error(bus_error), .sysclk(sysclk), .sysreset(sysreset));

/* testbench/vsc_master_model.sv */
// Purpose: backplane masters requesting on four levels
// Assumes: grant taken when seen, one service per raised want bit
// Notes: hold sets tenure, clear shortens it
module vsc_master_model (
  input wire core_clk, // clock
  input wire rst, // reset
  input wire [3:0] want, // levels wanting the bus
  input wire [7:0] hold, // tenure in cycles
  input wire [3:0] bus_grant, // grants
  input wire bus_clear, // clear
  output logic [3:0] bus_request, // requests
  output logic bus_busy_in // busy
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] served;
  logic [7:0] cnt;
  assign bus_request = want & ~served;
  // take grant, hold bus, release early on clear
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      served <= 4'h0;
      cnt <= 8'h00;
      bus_busy_in <= 1'b0;
    end else begin
      served <= served & want;
      if (bus_busy_in) begin
        if (bus_clear && cnt > 8'h02) cnt <= 8'h02;
        else if (cnt == 8'h00) bus_busy_in <= 1'b0;
        else cnt <= cnt - 8'h01;
      end else if (|(bus_grant & bus_request)) begin
        bus_busy_in <= 1'b1;
        served <= (served | bus_grant) & want;
        cnt <= hold;
      end
    end
  end
endmodule // vsc_master_model

/* testbench/test_vsc_arbiter.sv */
// Purpose: self checking bench of the system controller arbiter
// Assumes: timeout shortened to 20 cycles
// Notes: each mode is entered through a fresh reset
module test_vsc_arbiter;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 0, rst = 1, st = 1, ml = 0, rr = 0;
  logic cs = 0, ca = 0, own = 0, wr = 0, rd = 0, a, b;
  logic [3:0] want = 0, bq, g, e, m;
  logic [7:0] hold = 3, addr = 0;
  logic [31:0] wd = 0, rdat, d;
  logic bb, clr, og, be, sck, srst, irq;
  int err_count = 0, num_checks = 0, i, k;
  localparam logic [10:0] ROWS [5] = '{11'h4f8, 11'h470, 11'h664,
    11'h611, 11'h2f0};
  vsc_arbiter #(.TIMEOUT_CYC(20)) dut (.core_clk(core_clk), .rst(rst),
    .system_controller_enable_strap(st), .multilevel_arbiter_select(ml),
    .rotating_arbitration(rr), .bus_request(bq), .bus_busy_in(bb),
    .cycle_start(cs), .cycle_ack(ca), .own_request(own), .reg_addr(addr),
    .reg_wdata(wd), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdat),
    .bus_grant(g), .bus_clear(clr), .own_grant(og), .bus_error(be),
    .sysclk(sck), .sysreset(srst), .irq(irq));
  vsc_master_model u_m (.core_clk(core_clk), .rst(rst), .want(want),
    .hold(hold), .bus_grant(g), .bus_clear(clr), .bus_request(bq),
    .bus_busy_in(bb));
  always #20 core_clk = ~core_clk;
  task chk(input logic [31:0] s, input logic [31:0] x);
    num_checks++;
    if (s !== x) begin
      err_count++;
      $display("[ERR] %0t seen %h exp %h", $time, s, x);
    end
  endtask
  task wrap_up;
    if (err_count == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task rs(input logic s, input logic l, input logic r);
    @(posedge core_clk);
    {st, ml, rr, rst, want} <= {s, l, r, 1'b1, 4'h0};
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
  endtask
  task wreg(input logic [7:0] ad, input logic [31:0] v);
    @(posedge core_clk);
    {addr, wd, wr} <= {ad, v, 1'b1};
    @(posedge core_clk);
    wr <= 1'b0;
  endtask
  task rreg(input logic [7:0] ad, output logic [31:0] v);
    @(posedge core_clk);
    {addr, rd} <= {ad, 1'b1};
    @(posedge core_clk);
    rd <= 1'b0;
    @(negedge core_clk);
    v = rdat;
  endtask
  // wait for a grant, then for it to be taken
  task wg(output logic [3:0] q);
    q = 0;
    for (i = 0; i < 60 && q == 0; i++) begin
      @(negedge core_clk);
      q = g;
    end
    for (i = 0; i < 10 && g !== 0; i++) @(negedge core_clk);
  endtask
  initial begin
    #800000;
    err_count++;
    wrap_up;
  end
  initial begin
    // table of strap settings and first grant
    for (k = 0; k < 5; k++) begin
      rs(ROWS[k][10], ROWS[k][9], ROWS[k][8]);
      rreg(8'h00, d);
      chk(d, 0);
      rreg(8'h40, d);
      chk(d, 0);
      want <= ROWS[k][7:4];
      wg(m);
      chk(m, ROWS[k][3:0]);
    end
    // priority order of pending levels
    rs(1, 1, 0);
    want <= 4'hb;
    for (k = 3; k >= 0; k--) if (k != 2) begin
      wg(m);
      chk(m, 4'h1 << k);
    end
    // higher level arrives during a long tenure
    want <= 0;
    hold <= 200;
    @(posedge core_clk);
    want <= 4'h2;
    wg(m);
    want <= 4'ha;
    for (i = 0; i < 20 && clr !== 1; i++) @(negedge core_clk);
    chk(clr, 1);
    hold <= 3;
    wg(m);
    chk(m, 4'h8);
    // own mastership, release on request, then lock
    @(posedge core_clk);
    want <= 0;
    own <= 1;
    repeat (10) @(negedge core_clk);
    chk(og, 1);
    want <= 4'h1;
    for (i = 0; i < 40 && og !== 0; i++) @(negedge core_clk);
    chk(og, 0);
    want <= 0;
    for (i = 0; i < 40 && og !== 1; i++) @(negedge core_clk);
    wreg(8'h00, 1);
    want <= 4'h1;
    repeat (30) @(negedge core_clk);
    chk({og, g}, 5'h10);
    wreg(8'h00, 0);
    own <= 0;
    // rotating mode visits every level, optional clear
    rs(1, 1, 1);
    want <= 4'hf;
    e = 0;
    for (k = 0; k < 4; k++) begin
      wg(m);
      e = e | m;
    end
    chk(e, 4'hf);
    wreg(8'h00, 2);
    want <= 0;
    hold <= 200;
    @(posedge core_clk);
    want <= 4'h1;
    wg(m);
    want <= 4'h3;
    for (i = 0; i < 20 && clr !== 1; i++) @(negedge core_clk);
    chk(clr, 1);
    // timeout, status, interrupt mask
    rs(1, 1, 0);
    rreg(8'h04, d);
    wreg(8'h08, 0);
    cs <= 1;
    for (i = 0; i < 40 && be !== 1; i++) @(negedge core_clk);
    chk(i >= 18 && i <= 23, 1);
    @(posedge core_clk);
    cs <= 0;
    repeat (3) @(negedge core_clk);
    a = irq;
    wreg(8'h08, 7);
    repeat (2) @(negedge core_clk);
    b = irq;
    chk({a, b}, 2'h1);
    rreg(8'h04, d);
    chk(d, 32'h1);
    repeat (2) @(negedge core_clk);
    chk(irq, 0);
    @(posedge core_clk);
    cs <= 1;
    repeat (5) @(posedge core_clk);
    ca <= 1;
    @(posedge core_clk);
    ca <= 0;
    repeat (30) @(negedge core_clk);
    chk(be, 0);
    @(posedge core_clk);
    cs <= 0;
    // software request restarts the system reset pulse
    wreg(8'h00, 4);
    repeat (2) @(negedge core_clk);
    chk(srst, 1);
    wrap_up;
  end
endmodule // test_vsc_arbiter
